// *** core/nib_pkg.sv ***
// constants for the nibble memory and status flag block
package nib_pkg;
  localparam int unsigned IMEM_WORDS = 512;
  localparam int unsigned IMEM_WIDTH = 16;
  localparam int unsigned IP_WIDTH = 9;
  localparam logic [8:0] IP_RESET = 9'h000;
  localparam logic [8:0] IP_LAST = 9'h1ff;
  localparam int unsigned ROW_BITS = 3;
  localparam int unsigned COL_BITS = 4;
  localparam int unsigned DADDR_WIDTH = 7;
  localparam logic [2:0] GEN_ROW = 3'h0;
  localparam logic [6:0] PORT_B_ADDR = 7'h70;
  localparam logic [6:0] PORT_C_ADDR = 7'h71;
  localparam logic [6:0] PORT_D_ADDR = 7'h72;
  localparam logic [6:0] PORT_SPARE_ADDR = 7'h73;
  localparam logic [6:0] CTRL_ZERO_FIRST = 7'h74;
  localparam logic [6:0] CTRL_ZERO_LAST = 7'h7d;
  localparam logic [6:0] DECIMAL_MODE_NIBBLE = 7'h7e;
  localparam logic [6:0] ARITH_FLAG_NIBBLE = 7'h7f;
  localparam int unsigned DEC_BIT = 0;
  localparam int unsigned CMP_BIT = 3;
  localparam int unsigned CY_BIT = 2;
  localparam int unsigned Z_BIT = 1;
  localparam logic [3:0] DEC_MASK = 4'h1;
  localparam logic [3:0] FLAG_MASK = 4'he;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] PORT_RESET = 4'h0;
  localparam logic [3:0] BCD_LIMIT = 4'h9;
  localparam logic [3:0] BCD_ADJ = 4'h6;
  typedef enum logic [11:0] {
    OP_NONE  = 12'h001,
    OP_ADD   = 12'h002,
    OP_SUB   = 12'h004,
    OP_OR    = 12'h008,
    OP_AND   = 12'h010,
    OP_XOR   = 12'h020,
    OP_SKT   = 12'h040,
    OP_SKF   = 12'h080,
    OP_SKCMP = 12'h100,
    OP_ROTATE_RIGHT_THROUGH_CARRY  = 12'h200,
    OP_MOV   = 12'h400,
    OP_RSVD  = 12'h800
  } alu_op_type;
endpackage : nib_pkg

// *** core/nibble_memory_status_flags.sv ***
// storage, ports and status word of the nibble core
`timescale 1ns/1ps
module nibble_memory_status_flags import nib_pkg::*; #(
  parameter int unsigned PORT_COUNT = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // instruction pointer control
  input wire logic ip_step,
  input wire logic ip_load,
  input wire logic [8:0] ip_load_value,
  output logic [8:0] instr_pointer,
  // instruction store
  input wire logic imem_we,
  input wire logic [8:0] imem_waddr,
  input wire logic [15:0] imem_wdata,
  output logic [15:0] instr_word,
  // data memory access from the sequencer
  input wire logic [6:0] mem_addr,
  input wire logic [3:0] gen_col,
  input wire logic mem_we,
  input wire logic [3:0] mem_wdata,
  output logic [3:0] mem_rdata,
  output logic [3:0] gen_rdata,
  // alu operation strobe
  input wire logic op_valid,
  input wire alu_op_type op_code,
  input wire logic op_to_gen,
  input wire logic op_use_carry,
  input wire logic [3:0] op_a,
  input wire logic [3:0] op_b,
  output logic op_skip,
  output logic [3:0] op_result,
  // ports
  input wire logic [3:0] port_pins_in [PORT_COUNT],
  output logic [3:0] port_out [PORT_COUNT],
  output logic [PORT_COUNT-1:0] port_oe,
  // status view
  output logic [2:0] row_select_pointer,
  output logic decimal_mode,
  output logic compare_hold_flag,
  output logic carry_bit,
  output logic zero_flag
);

  ////////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic is_port(input logic [6:0] a);
    is_port = (a >= PORT_B_ADDR) && (a <= PORT_SPARE_ADDR);
  endfunction : is_port

  function automatic logic is_sys(input logic [6:0] a);
    is_sys = (a >= CTRL_ZERO_FIRST);
  endfunction : is_sys

  ////////////////////////////////////////////////////////////////////////////////
  // instruction pointer and store

  logic [8:0] ip_r;
  logic [15:0] imem [IMEM_WORDS];
  logic [15:0] instr_word_r;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ip_r <= IP_RESET;
    end else if (ip_load) begin
      ip_r <= ip_load_value;
    end else if (ip_step) begin
      ip_r <= (ip_r == IP_LAST) ? IP_RESET : ip_r + 9'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (imem_we) begin
      imem[imem_waddr] <= imem_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      instr_word_r <= 16'h0000;
    end else begin
      instr_word_r <= imem[ip_r];
    end
  end

  assign instr_pointer = ip_r;
  assign instr_word = instr_word_r;

  ////////////////////////////////////////////////////////////////////////////////
  // alu

  logic dec_r;
  logic cmp_r;
  logic cy_r;
  logic z_r;
  logic [4:0] raw;
  logic [3:0] res;
  logic res_cy;
  logic skip_c;
  logic arith;
  logic cin;

  assign arith = (op_code == OP_ADD) || (op_code == OP_SUB);
  assign cin = op_use_carry & cy_r;

  always_comb begin
    raw = 5'h00;
    res = 4'h0;
    res_cy = 1'b0;
    skip_c = 1'b0;
    case (op_code)
      OP_ADD: begin
        raw = {1'b0, op_a} + {1'b0, op_b} + {4'h0, cin};
        if (dec_r && (raw[4] || (raw[3:0] > BCD_LIMIT))) begin
          res = raw[3:0] + BCD_ADJ;
          res_cy = 1'b1;
        end else begin
          res = raw[3:0];
          res_cy = raw[4];
        end
      end
      OP_SUB, OP_SKCMP: begin
        raw = {1'b0, op_a} - {1'b0, op_b} - {4'h0, cin};
        res_cy = raw[4];
        res = (dec_r && raw[4]) ? raw[3:0] - BCD_ADJ : raw[3:0];
        skip_c = raw[4];
      end
      OP_OR: res = op_a | op_b;
      OP_AND: res = op_a & op_b;
      OP_XOR: res = op_a ^ op_b;
      OP_SKT: skip_c = ((op_a & op_b) == op_b);
      OP_SKF: skip_c = ((op_a & op_b) == 4'h0);
      OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        res = {cy_r, op_a[3:1]};
        res_cy = op_a[0];
      end
      OP_MOV: res = op_a;
      default: begin
        res = 4'h0;
      end
    endcase
  end

  assign op_result = res;
  assign op_skip = op_valid & skip_c;

  logic alu_store;
  logic alu_gen_we;
  logic alu_mem_we;
  assign alu_store = op_valid && (op_code inside {OP_ADD, OP_SUB, OP_OR, OP_AND, OP_XOR,
                     OP_ROTATE_RIGHT_THROUGH_CARRY, OP_MOV}) && !(arith && cmp_r);
  assign alu_gen_we = alu_store && (op_to_gen || (op_code == OP_ROTATE_RIGHT_THROUGH_CARRY));
  assign alu_mem_we = alu_store && !alu_gen_we;

  ////////////////////////////////////////////////////////////////////////////////
  // data memory

  logic [3:0] dmem [112];
  logic [6:0] gen_addr;
  logic [6:0] wr_addr;
  logic [3:0] wr_data;
  logic wr_en;

  assign row_select_pointer = GEN_ROW;
  assign gen_addr = {GEN_ROW, gen_col};
  assign wr_en = mem_we | alu_gen_we | alu_mem_we;
  assign wr_addr = alu_gen_we ? gen_addr : mem_addr;
  assign wr_data = (alu_gen_we | alu_mem_we) ? res : mem_wdata;

  always_ff @(posedge clk) begin
    if (wr_en && !is_port(wr_addr) && !is_sys(wr_addr)) begin
      dmem[wr_addr] <= wr_data;
    end
  end

  function automatic logic [3:0] rd(input logic [6:0] a, input logic [3:0] m,
      input logic [3:0] p, input logic [3:0] dw, input logic [3:0] fw);
    logic [3:0] v;
    v = 4'h0;
    if (a == DECIMAL_MODE_NIBBLE) begin
      v = dw;
    end else if (a == ARITH_FLAG_NIBBLE) begin
      v = fw;
    end else if (is_sys(a)) begin
      v = 4'h0;
    end else if (is_port(a)) begin
      v = (int'(a[1:0]) < PORT_COUNT) ? p : 4'h0;
    end else begin
      v = m;
    end
    rd = v;
  endfunction : rd

  ////////////////////////////////////////////////////////////////////////////////
  // ports

  logic [3:0] port_meta_r [PORT_COUNT];
  logic [3:0] port_sync_r [PORT_COUNT];
  logic [3:0] port_r [PORT_COUNT];
  logic [PORT_COUNT-1:0] port_oe_r;

  generate
    for (genvar p = 0; p < PORT_COUNT; p++) begin : g_port
      always_ff @(posedge clk) begin
        port_meta_r[p] <= port_pins_in[p];
        port_sync_r[p] <= port_meta_r[p];
      end
      always_ff @(posedge clk) begin
        if (!resetn) begin
          port_r[p] <= PORT_RESET;
          port_oe_r[p] <= 1'b0;
        end else if (wr_en && (wr_addr == PORT_B_ADDR + 7'(p))) begin
          port_r[p] <= wr_data;
          port_oe_r[p] <= 1'b1;
        end
      end
      assign port_out[p] = port_r[p];
    end
  endgenerate

  assign port_oe = port_oe_r;

  ////////////////////////////////////////////////////////////////////////////////
  // status word (the status flip-flops themselves)

  logic st_dec_we;
  logic st_flag_we;
  assign st_dec_we = wr_en && (wr_addr == DECIMAL_MODE_NIBBLE);
  assign st_flag_we = wr_en && (wr_addr == ARITH_FLAG_NIBBLE);

  always_ff @(posedge clk) begin
    if (!resetn) begin
      dec_r <= STATUS_RESET[DEC_BIT];
    end else if (st_dec_we) begin
      dec_r <= wr_data[DEC_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cmp_r <= STATUS_RESET[CMP_BIT];
    end else if (st_flag_we) begin
      cmp_r <= wr_data[CMP_BIT];
    end else if (op_valid && ((op_code == OP_SKT) || (op_code == OP_SKF))) begin
      cmp_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cy_r <= STATUS_RESET[CY_BIT];
    end else if (st_flag_we) begin
      cy_r <= wr_data[CY_BIT];
    end else if (op_valid && (arith || (op_code == OP_ROTATE_RIGHT_THROUGH_CARRY))) begin
      cy_r <= res_cy;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      z_r <= STATUS_RESET[Z_BIT];
    end else if (st_flag_we) begin
      z_r <= wr_data[Z_BIT];
    end else if (op_valid && arith) begin
      if (res != 4'h0) begin
        z_r <= 1'b0;
      end else if (!cmp_r) begin
        z_r <= 1'b1;
      end
    end
  end

  assign decimal_mode = dec_r;
  assign compare_hold_flag = cmp_r;
  assign carry_bit = cy_r;
  assign zero_flag = z_r;

  ////////////////////////////////////////////////////////////////////////////////
  // read path, memory and status values passed in so reads follow each update; port reads return the synchronized pins, not port_r

  logic [3:0] pin_word;
  logic [3:0] dec_word;
  logic [3:0] flag_word;

  always_comb begin
    pin_word = 4'h0;
    for (int i = 0; i < PORT_COUNT; i++) begin
      if (mem_addr[1:0] == 2'(i)) begin
        pin_word = port_sync_r[i];
      end
    end
  end

  assign dec_word = {3'b000, dec_r};
  assign flag_word = {cmp_r, cy_r, z_r, 1'b0};
  assign mem_rdata = rd(mem_addr, dmem[mem_addr], pin_word, dec_word, flag_word);
  assign gen_rdata = rd(gen_addr, dmem[gen_addr], 4'h0, dec_word, flag_word);

endmodule : nibble_memory_status_flags

// *** tb/nib_sva.sv ***
// bound assertions and covers for the nibble memory and status flag block
`timescale 1ns/1ps
module nib_chk import nib_pkg::*; (
  // clock, reset, pointer
  input wire logic clk,
  input wire logic resetn,
  input wire logic ip_step,
  input wire logic ip_load,
  input wire logic [8:0] instr_pointer,
  // memory and alu
  input wire logic [6:0] mem_addr,
  input wire logic mem_we,
  input wire logic [3:0] mem_wdata,
  input wire logic [3:0] mem_rdata,
  input wire logic op_valid,
  input wire alu_op_type op_code,
  input wire logic [3:0] op_a,
  input wire logic [3:0] op_result,
  // flags
  input wire logic compare_hold_flag,
  input wire logic carry_bit,
  input wire logic zero_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  logic ar;
  logic ov;
  assign ov = op_valid && !mem_we;
  assign ar = ov && (op_code == OP_ADD || op_code == OP_SUB);
  a_reset_clear: assert property (!$past(resetn) |-> instr_pointer == 9'h000
    && !carry_bit && !zero_flag && !compare_hold_flag) else $error("reset state wrong");
  a_ip_step: assert property (ip_step && !ip_load |=>
    instr_pointer == 9'($past(instr_pointer) + 9'h001)) else $error("step wrong");
  a_ctrl_zero: assert property (mem_addr >= 7'h74 && mem_addr <= 7'h7d |->
    mem_rdata == 4'h0) else $error("control area not zero");
  a_fixed_bits: assert property (mem_addr[6:1] == 6'h3f |->
    (mem_addr[0] ? !mem_rdata[0] : mem_rdata[3:1] == 3'h0)) else $error("fixed bit set");
  a_zero_clear: assert property (ar && op_result != 4'h0 |=> !zero_flag)
    else $error("zero kept");
  a_zero_hold: assert property (ar && op_result == 4'h0 |=>
    zero_flag == ($past(compare_hold_flag) ? $past(zero_flag) : 1'b1)) else $error("zero wrong");
  a_rotate_carry: assert property (ov && op_code == OP_ROTATE_RIGHT_THROUGH_CARRY |=>
    {3'h0, carry_bit} == ($past(op_a) & 4'h1)) else $error("rotate carry wrong");
  a_skip_clears: assert property (ov && (op_code == OP_SKT || op_code == OP_SKF) |=>
    !compare_hold_flag) else $error("hold kept");
  a_cmp_carry: assert property (ov && op_code == OP_SKCMP |=> $stable(carry_bit))
    else $error("compare moved carry");
  a_status_write: assert property (mem_we && !op_valid && mem_addr == 7'h7f |=>
    {compare_hold_flag, carry_bit, zero_flag, 1'b0} == ($past(mem_wdata) & 4'he))
    else $error("status write lost");
  c_rotate: cover property (ov && op_code == OP_ROTATE_RIGHT_THROUGH_CARRY);
  c_held_zero: cover property (ar && compare_hold_flag && op_result == 4'h0);
  c_status: cover property (mem_we && mem_addr == 7'h7f);
endmodule : nib_chk
bind nibble_memory_status_flags nib_chk nib_chk_i (.clk, .resetn, .ip_step, .ip_load,
  .instr_pointer, .mem_addr, .mem_we, .mem_wdata, .mem_rdata, .op_valid, .op_code, .op_a,
  .op_result, .compare_hold_flag, .carry_bit, .zero_flag);

// *** tb/port_pin_model.sv ***
// pin levels: driven value with shorted bits, or outside level
`timescale 1ns/1ps
module port_pin_model #(
  parameter int unsigned N = 4
) (
  // port side
  input wire logic [3:0] port_out [N],
  input wire logic [N-1:0] port_oe,
  // outside
  input wire logic [3:0] ext_level [N],
  input wire logic [3:0] short_mask,
  output logic [3:0] pins [N]
);
  always_comb begin
    for (int i = 0; i < N; i++) begin
      pins[i] = port_oe[i] ? (port_out[i] & ~short_mask) : ext_level[i];
    end
  end
endmodule : port_pin_model

// *** tb/test_nibble_memory_status_flags.sv ***
// self-checking bench for the nibble memory and status flag block
`timescale 1ns/1ps
module test_nibble_memory_status_flags import nib_pkg::*; ;
  logic clk = 0, resetn = 0, ip_step = 0, ip_load = 0, imem_we = 0, mem_we = 0;
  logic op_valid = 0, op_to_gen = 0, op_use_carry = 0, op_skip;
  logic [8:0] ip_load_value = '0, imem_waddr = '0, instr_pointer;
  logic [15:0] imem_wdata = '0, instr_word;
  logic [6:0] mem_addr = '0;
  logic [3:0] gen_col = '0, mem_wdata = '0, op_a = '0, op_b = '0, sm = '0;
  logic [3:0] mem_rdata, gen_rdata, op_result, port_oe;
  alu_op_type op_code = OP_NONE;
  logic [3:0] port_out [4], port_pins_in [4], ext [4];
  logic [2:0] row_select_pointer;
  logic decimal_mode, compare_hold_flag, carry_bit, zero_flag;
  int error_cnt = 0, comparisons = 0;
  assign ext = '{4'h5, 4'h6, 4'h9, 4'h3};
  nibble_memory_status_flags nibble_memory_status_flags_i (.clk, .resetn, .ip_step, .ip_load,
    .ip_load_value, .instr_pointer, .imem_we, .imem_waddr, .imem_wdata, .instr_word, .mem_addr,
    .gen_col, .mem_we, .mem_wdata, .mem_rdata, .gen_rdata, .op_valid, .op_code, .op_to_gen,
    .op_use_carry, .op_a, .op_b, .op_skip, .op_result, .port_pins_in, .port_out, .port_oe,
    .row_select_pointer, .decimal_mode, .compare_hold_flag, .carry_bit, .zero_flag);
  port_pin_model port_pin_model_i (.port_out, .port_oe, .ext_level(ext), .short_mask(sm),
    .pins(port_pins_in));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic fl(input logic [3:0] e);
    chk({compare_hold_flag, carry_bit, zero_flag, decimal_mode}, e);
  endtask : fl
  task automatic wr(input logic [6:0] ad, input logic [3:0] d);
    @(posedge clk);
    mem_addr <= ad;
    mem_wdata <= d;
    mem_we <= 1'b1;
    @(posedge clk);
    mem_we <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [6:0] ad, input logic [3:0] e);
    @(posedge clk);
    mem_addr <= ad;
    #1 chk(mem_rdata, e);
  endtask : rd
  task automatic op(input alu_op_type c, input logic [6:0] ad, input logic [3:0] x, y, e);
    @(posedge clk);
    op_code <= c;
    mem_addr <= ad;
    op_a <= x;
    op_b <= y;
    op_valid <= 1'b1;
    #1;
    if (c inside {OP_SKT, OP_SKF, OP_SKCMP}) chk(op_skip, e);
    else chk(op_result, e);
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask : op
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////
  initial begin
    #50000;
    error_cnt++;
    $display("ERROR at %0t: timeout", $time);
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    #1 chk(instr_pointer, 9'h000);
    fl(4'h0);
    @(posedge clk);
    imem_we <= 1'b1;
    imem_waddr <= 9'h1ff;
    imem_wdata <= 16'h1234;
    @(posedge clk);
    imem_waddr <= 9'h000;
    imem_wdata <= 16'h5a5a;
    @(posedge clk);
    imem_we <= 1'b0;
    ip_load <= 1'b1;
    ip_step <= 1'b1;
    ip_load_value <= 9'h1ff;
    @(posedge clk);
    ip_load <= 1'b0;
    #1 chk(instr_pointer, 9'h1ff);
    @(posedge clk);
    ip_step <= 1'b0;
    #1 chk(instr_pointer, 9'h000);
    chk(instr_word, 16'h1234);
    @(posedge clk);
    #1 chk(instr_word, 16'h5a5a);
    $display("pointer test done");
    wr(7'h35, 4'hc);
    wr(7'h05, 4'h9);
    @(posedge clk) gen_col <= 4'h5;
    rd(7'h35, 4'hc);
    chk(gen_rdata, 4'h9);
    chk(row_select_pointer, 3'h0);
    for (int i = 'h74; i <= 'h7d; i++) begin
      wr(7'(i), 4'hf);
      rd(7'(i), 4'h0);
    end
    wr(7'h7e, 4'hf);
    rd(7'h7e, 4'h1);
    wr(7'h7f, 4'hf);
    rd(7'h7f, 4'he);
    fl(4'hf);
    wr(7'h7f, 4'h0);
    wr(7'h7e, 4'h0);
    $display("memory test done");
    op(OP_ADD, 7'h10, 4'h7, 4'h9, 4'h0);
    fl(4'h6);
    rd(7'h10, 4'h0);
    @(posedge clk) op_use_carry <= 1'b1;
    op(OP_ADD, 7'h11, 4'h2, 4'h3, 4'h6);
    fl(4'h0);
    @(posedge clk) op_use_carry <= 1'b0;
    op(OP_SUB, 7'h12, 4'h3, 4'h5, 4'he);
    fl(4'h4);
    wr(7'h7e, 4'h1);
    op(OP_ADD, 7'h13, 4'h7, 4'h5, 4'h2);
    fl(4'h5);
    op(OP_SUB, 7'h13, 4'h3, 4'h5, 4'h8);
    wr(7'h7e, 4'h0);
    op(OP_OR, 7'h15, 4'h9, 4'h6, 4'hf);
    op(OP_AND, 7'h16, 4'hc, 4'ha, 4'h8);
    op(OP_XOR, 7'h17, 4'hc, 4'ha, 4'h6);
    op(OP_MOV, 7'h18, 4'h3, 4'h0, 4'h3);
    rd(7'h16, 4'h8);
    rd(7'h18, 4'h3);
    $display("arithmetic test done");
    wr(7'h14, 4'h5);
    wr(7'h7f, 4'ha);
    op(OP_SUB, 7'h14, 4'h5, 4'h5, 4'h0);
    fl(4'ha);
    op(OP_SUB, 7'h14, 4'h6, 4'h5, 4'h1);
    fl(4'h8);
    op(OP_SUB, 7'h14, 4'h4, 4'h5, 4'hf);
    fl(4'hc);
    op(OP_SUB, 7'h14, 4'h5, 4'h5, 4'h0);
    fl(4'h8);
    rd(7'h14, 4'h5);
    @(posedge clk) op_to_gen <= 1'b1;
    op(OP_ADD, 7'h14, 4'h1, 4'h1, 4'h2);
    chk(gen_rdata, 4'h9);
    @(posedge clk) op_to_gen <= 1'b0;
    op(OP_SUB, 7'h14, 4'h4, 4'h5, 4'hf);
    op(OP_SKCMP, 7'h14, 4'h7, 4'h2, 4'h0);
    fl(4'hc);
    op(OP_SKT, 7'h14, 4'hb, 4'h3, 4'h1);
    fl(4'h4);
    wr(7'h7f, 4'h8);
    op(OP_SKF, 7'h14, 4'hb, 4'h4, 4'h1);
    fl(4'h0);
    $display("compare test done");
    wr(7'h7f, 4'h4);
    @(posedge clk);
    op_to_gen <= 1'b1;
    gen_col <= 4'h2;
    op(OP_ROTATE_RIGHT_THROUGH_CARRY, 7'h14, 4'h3, 4'h0, 4'h9);
    fl(4'h4);
    chk(gen_rdata, 4'h9);
    op(OP_ROTATE_RIGHT_THROUGH_CARRY, 7'h14, 4'h2, 4'h0, 4'h9);
    fl(4'h0);
    op(OP_ADD, 7'h14, 4'h4, 4'h4, 4'h8);
    chk(gen_rdata, 4'h8);
    @(posedge clk) op_to_gen <= 1'b0;
    $display("rotate test done");
    rd(PORT_B_ADDR, 4'h5);
    sm <= 4'h3;
    wr(PORT_B_ADDR, 4'hf);
    chk(port_oe, 4'h1);
    chk(port_out[0], 4'hf);
    repeat (2) @(posedge clk);
    rd(PORT_B_ADDR, 4'hc);
    wr(PORT_C_ADDR, 4'h6);
    chk(port_oe, 4'h3);
    chk(port_out[1], 4'h6);
    chk(port_out[0], 4'hf);
    repeat (2) @(posedge clk);
    rd(PORT_C_ADDR, 4'h4);
    @(posedge clk);
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    #1 chk(port_oe, 4'h0);
    chk(port_out[0], 4'h0);
    fl(4'h0);
    $display("port test done");
    wrap_up();
  end
endmodule : test_nibble_memory_status_flags
